// [hdl/power_clock_manager.sv]
// power and clock manager: derives processor, master, memory, usb and
// peripheral clocks as one-cycle ticks; assumes source ticks are synchronous
// How it works
// - master clock is the prescaled system clock divided by one, two, three or four.
// - memory clock ticks exactly twice per master clock period when the master divider is two, three or four.
// - memory clock is silent while the master divider is one.
// - the full-speed usb divider divides by its field value plus one.
// - the full-speed usb source is the usb pll or the main pll.
// - master select 11 divides by three and 01 divides by two.
// - system source picks main pll, usb pll, oscillator or slow clock, then prescales.
// - idle mode stops the processor clock until an interrupt.
// - slow mode runs processor and peripherals from the slow clock.
// - standby stops the processor until an interrupt, peripherals on slow clock.
// - each peripheral has its own switchable clock at master rate.
// - two programmable clock outputs each pick a source and a prescale.
// - usb pll clock passes straight on as the high-speed host clock.
// - two full-speed host clocks, 48 MHz and 12 MHz, come from the fs divider.
`timescale 1ns/1ps
module power_clock_manager #(
    parameter int NUM_PERIPH = 32
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic usbPllTick,
    input wire logic mainPllTick,
    input wire logic slowTick,
    input wire logic mainOscTick,
    input wire logic [1:0] sysSrcSel,
    input wire logic [2:0] sysPresSel,
    input wire logic [1:0] masterDivSelect,
    input wire logic fsUsbSrcSel,
    input wire logic [3:0] fsUsbDivider,
    input wire logic [NUM_PERIPH-1:0] periphClkEn,
    input wire logic [1:0] progASrcSel,
    input wire logic [2:0] progAPresSel,
    input wire logic [1:0] progBSrcSel,
    input wire logic [2:0] progBPresSel,
    input wire logic modeReq,
    input wire logic [1:0] modeReqCode,
    input wire logic wakeIrq,
    output logic procClockTick,
    output logic masterClockTick,
    output logic memClockTick,
    output logic hsHostClockTick,
    output logic fsHost48mClockTick,
    output logic fsHost12mClockTick,
    output logic [NUM_PERIPH-1:0] periphClockTick,
    output logic progClockOutA,
    output logic progClockOutB,
    output logic [1:0] modeState
);
    function automatic logic pickSrc(input logic [1:0] sel, input logic pll,
                                     input logic upll, input logic osc, input logic slw);
        case (sel)
            power_clock_pkg::SRC_MAIN_PLL: pickSrc = pll;
            power_clock_pkg::SRC_USB_PLL: pickSrc = upll;
            power_clock_pkg::SRC_MAIN_OSC: pickSrc = osc;
            default: pickSrc = slw;
        endcase
    endfunction : pickSrc

    // last count of a 2**sel divider; selections above 6 clamp to /64
    function automatic logic [5:0] presLast(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > power_clock_pkg::PRES_MAX_SEL) ? power_clock_pkg::PRES_MAX_SEL : sel;
        presLast = 6'(7'h01 << s) - 6'h01;
    endfunction : presLast

    power_clock_pkg::pwr_mode_e mode_r;
    logic [1:0] sysSrcLat_r;
    logic [2:0] presLat_r;
    logic [5:0] presCnt_r;
    logic pckRaw_r;
    logic [1:0] mdivLat_r;
    logic [1:0] mckCnt_r;
    logic [1:0] mLast;
    logic [1:0] mHalf;
    logic masterFire;
    logic sysSrcTick;
    logic lowPower;
    logic procRun;
    logic fsSrcLat_r;
    logic [3:0] fsDivLat_r;
    logic [3:0] fsCnt_r;
    logic [1:0] fs12Cnt_r;
    logic fsSrcTick;
    logic [1:0] progSrc [2];
    logic [2:0] progPres [2];
    logic [1:0] progTick_r;

    assign lowPower = (mode_r == power_clock_pkg::MODE_SLOW) ||
                      (mode_r == power_clock_pkg::MODE_STANDBY);
    assign procRun = (mode_r == power_clock_pkg::MODE_NORMAL) ||
                     (mode_r == power_clock_pkg::MODE_SLOW);
    assign modeState = mode_r;

    // wake interrupt beats a simultaneous mode request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= power_clock_pkg::MODE_NORMAL;
        end else if (wakeIrq && mode_r == power_clock_pkg::MODE_IDLE) begin
            mode_r <= power_clock_pkg::MODE_NORMAL;
        end else if (wakeIrq && mode_r == power_clock_pkg::MODE_STANDBY) begin
            mode_r <= power_clock_pkg::MODE_SLOW;
        end else if (modeReq) begin
            mode_r <= power_clock_pkg::pwr_mode_e'(modeReqCode);
        end
    end

    // system source and prescaler; new settings latched only on wrap, so a
    // stopped old source holds the switch until it ticks up to its prescaler wrap
    assign sysSrcTick = pickSrc(sysSrcLat_r, mainPllTick, usbPllTick, mainOscTick, slowTick);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sysSrcLat_r <= power_clock_pkg::SRC_RST;
            presLat_r <= power_clock_pkg::PRES_RST;
            presCnt_r <= '0;
            pckRaw_r <= 1'b0;
        end else if (sysSrcTick && presCnt_r >= presLast(presLat_r)) begin
            presCnt_r <= '0;
            pckRaw_r <= 1'b1;
            presLat_r <= sysPresSel;
            sysSrcLat_r <= lowPower ? power_clock_pkg::SRC_SLOW : sysSrcSel;
        end else begin
            presCnt_r <= sysSrcTick ? presCnt_r + 6'h01 : presCnt_r;
            pckRaw_r <= 1'b0;
        end
    end

    always_comb begin
        case (mdivLat_r)
            power_clock_pkg::MASTER_DIV_SELECT_DIV2: begin mLast = 2'h1; mHalf = 2'h1; end
            power_clock_pkg::MASTER_DIV_SELECT_DIV3: begin mLast = 2'h2; mHalf = 2'h1; end
            power_clock_pkg::MASTER_DIV_SELECT_DIV4: begin mLast = 2'h3; mHalf = 2'h2; end
            default: begin mLast = 2'h0; mHalf = 2'h0; end
        endcase
    end
    assign masterFire = pckRaw_r && (mckCnt_r >= mLast);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mdivLat_r <= power_clock_pkg::MASTER_DIV_SELECT_RST;
            mckCnt_r <= '0;
        end else if (masterFire) begin
            mckCnt_r <= '0;
            mdivLat_r <= masterDivSelect;
        end else if (pckRaw_r) begin
            mckCnt_r <= mckCnt_r + 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            procClockTick <= 1'b0;
            masterClockTick <= 1'b0;
            memClockTick <= 1'b0;
            periphClockTick <= '0;
        end else begin
            procClockTick <= pckRaw_r && procRun;
            masterClockTick <= masterFire;
            // for /3 the two ticks are unevenly spaced but the rate is exact
            memClockTick <= pckRaw_r && (mdivLat_r != power_clock_pkg::MASTER_DIV_SELECT_DIV1) &&
                            (mckCnt_r == 2'h0 || mckCnt_r == mHalf);
            periphClockTick <= {NUM_PERIPH{masterFire}} & periphClkEn;
        end
    end

    // usb clocks; hs host clock needs the usb pll running
    assign fsSrcTick = fsSrcLat_r ? mainPllTick : usbPllTick;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hsHostClockTick <= 1'b0;
            fsSrcLat_r <= 1'b0;
            fsDivLat_r <= power_clock_pkg::FS_DIV_RST;
            fsCnt_r <= '0;
            fs12Cnt_r <= '0;
            fsHost48mClockTick <= 1'b0;
            fsHost12mClockTick <= 1'b0;
        end else begin
            hsHostClockTick <= usbPllTick;
            fsHost48mClockTick <= 1'b0;
            fsHost12mClockTick <= 1'b0;
            if (fsSrcTick && fsCnt_r >= fsDivLat_r) begin
                fsCnt_r <= '0;
                fsSrcLat_r <= fsUsbSrcSel;
                fsDivLat_r <= fsUsbDivider;
                fsHost48mClockTick <= 1'b1;
                fs12Cnt_r <= fs12Cnt_r + 2'h1;
                fsHost12mClockTick <= (fs12Cnt_r == power_clock_pkg::FS_12M_LAST);
            end else if (fsSrcTick) begin
                fsCnt_r <= fsCnt_r + 4'h1;
            end
        end
    end

    assign progSrc[0] = progASrcSel;
    assign progSrc[1] = progBSrcSel;
    assign progPres[0] = progAPresSel;
    assign progPres[1] = progBPresSel;

    for (genvar g = 0; g < 2; g++) begin : gProg
        logic [1:0] srcLat_r;
        logic [2:0] presSelLat_r;
        logic [5:0] cnt_r;
        logic srcTick;
        assign srcTick = pickSrc(srcLat_r, mainPllTick, usbPllTick, mainOscTick, slowTick);
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                srcLat_r <= power_clock_pkg::SRC_RST;
                presSelLat_r <= power_clock_pkg::PRES_RST;
                cnt_r <= '0;
                progTick_r[g] <= 1'b0;
            end else if (srcTick && cnt_r >= presLast(presSelLat_r)) begin
                cnt_r <= '0;
                srcLat_r <= progSrc[g];
                presSelLat_r <= progPres[g];
                progTick_r[g] <= 1'b1;
            end else begin
                cnt_r <= srcTick ? cnt_r + 6'h01 : cnt_r;
                progTick_r[g] <= 1'b0;
            end
        end
    end
    assign progClockOutA = progTick_r[0];
    assign progClockOutB = progTick_r[1];

    property p_idle_stops;
        @(posedge core_clk) disable iff (!rst_b)
        mode_r == power_clock_pkg::MODE_IDLE |=> !procClockTick;
    endproperty
    a_idle_stops: assert property (p_idle_stops) else $error("proc tick in idle");
    property p_idle_wake;
        @(posedge core_clk) disable iff (!rst_b)
        (mode_r == power_clock_pkg::MODE_IDLE && wakeIrq) |=>
            mode_r == power_clock_pkg::MODE_NORMAL;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake");
    property p_standby_wake;
        @(posedge core_clk) disable iff (!rst_b)
        (mode_r == power_clock_pkg::MODE_STANDBY && wakeIrq) |=>
            mode_r == power_clock_pkg::MODE_SLOW;
    endproperty
    a_standby_wake: assert property (p_standby_wake) else $error("standby no wake");
    property p_mem_off_div1;
        @(posedge core_clk) disable iff (!rst_b)
        mdivLat_r == power_clock_pkg::MASTER_DIV_SELECT_DIV1 |=> !memClockTick;
    endproperty
    a_mem_off_div1: assert property (p_mem_off_div1) else $error("mem tick at div1");
    property p_div2_mem;
        @(posedge core_clk) disable iff (!rst_b)
        (pckRaw_r && mdivLat_r == power_clock_pkg::MASTER_DIV_SELECT_DIV2) |=> memClockTick;
    endproperty
    a_div2_mem: assert property (p_div2_mem) else $error("mem tick missing");
    property p_master_div3;
        @(posedge core_clk) disable iff (!rst_b)
        (masterFire && mdivLat_r == power_clock_pkg::MASTER_DIV_SELECT_DIV3 &&
         masterDivSelect == power_clock_pkg::MASTER_DIV_SELECT_DIV3) |=> mckCnt_r == 2'h0 ##0
            (!masterFire [*2]);
    endproperty
    a_master_div3: assert property (p_master_div3) else $error("div3 spacing");
    property p_periph_gate;
        @(posedge core_clk) disable iff (!rst_b)
        periphClockTick[0] |-> ($past(periphClkEn[0]) && masterClockTick);
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("periph tick ungated");
    property p_hs_pass;
        @(posedge core_clk) disable iff (!rst_b)
        usbPllTick |=> hsHostClockTick;
    endproperty
    a_hs_pass: assert property (p_hs_pass) else $error("hs tick missing");
    property p_fs12_sub;
        @(posedge core_clk) disable iff (!rst_b)
        fsHost12mClockTick |-> fsHost48mClockTick;
    endproperty
    a_fs12_sub: assert property (p_fs12_sub) else $error("12m without 48m");
    property p_slow_src;
        @(posedge core_clk) disable iff (!rst_b)
        (lowPower && pckRaw_r && $past(lowPower)) |-> sysSrcLat_r == power_clock_pkg::SRC_SLOW;
    endproperty
    a_slow_src: assert property (p_slow_src) else $error("low power not on slow");
endmodule : power_clock_manager

// [common/power_clock_pkg.sv]
// constants and types shared by the power and clock manager
// all input clocks arrive as one-cycle ticks synchronous to core_clk
package power_clock_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_IDLE    = 2'b01,
        MODE_STANDBY = 2'b11,
        MODE_SLOW    = 2'b10
    } pwr_mode_e;
    // clock source select codes, shared by system and programmable outputs
    localparam logic [1:0] SRC_MAIN_PLL = 2'h0;
    localparam logic [1:0] SRC_USB_PLL = 2'h1;
    localparam logic [1:0] SRC_MAIN_OSC = 2'h2;
    localparam logic [1:0] SRC_SLOW = 2'h3;
    // master divider select decode
    localparam logic [1:0] MASTER_DIV_SELECT_DIV1 = 2'h0;
    localparam logic [1:0] MASTER_DIV_SELECT_DIV2 = 2'h1;
    localparam logic [1:0] MASTER_DIV_SELECT_DIV4 = 2'h2;
    localparam logic [1:0] MASTER_DIV_SELECT_DIV3 = 2'h3;
    // prescaler field: divide by 2**sel, sel 0..6
    localparam int PRES_W = 3;
    localparam int PRES_CNT_W = 6;
    localparam logic [2:0] PRES_MAX_SEL = 3'h6;
    localparam int FS_DIV_W = 4;
    localparam logic [3:0] FS_DIV_RST = 4'h9;
    localparam logic [1:0] FS_12M_LAST = 2'h3;
    localparam logic [1:0] SRC_RST = 2'h3;
    localparam logic [2:0] PRES_RST = 3'h0;
    localparam logic [1:0] MASTER_DIV_SELECT_RST = 2'h0;
endpackage : power_clock_pkg

// [tb/tb.sv]
// self-checking bench for the power and clock manager
// source clocks are periodic one-cycle ticks made here; outputs are counted
// over windows that span whole output periods, so the counts are exact
`timescale 1ns/1ps
module tb;
    localparam int LIMIT = 30000;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic usbPllTick = 1'b0;
    logic mainPllTick = 1'b0;
    logic slowTick = 1'b0;
    logic mainOscTick = 1'b0;
    logic [1:0] sysSrcSel = 2'h3;
    logic [2:0] sysPresSel = 3'h0;
    logic [1:0] masterDivSelect = 2'h0;
    logic fsUsbSrcSel = 1'b0;
    logic [3:0] fsUsbDivider = 4'h9;
    logic [31:0] periphClkEn = 32'h000000A5;
    logic [1:0] progASrcSel = 2'h3;
    logic [2:0] progAPresSel = 3'h0;
    logic [1:0] progBSrcSel = 2'h3;
    logic [2:0] progBPresSel = 3'h0;
    logic modeReq = 1'b0;
    logic [1:0] modeReqCode = 2'h0;
    logic wakeIrq = 1'b0;
    logic procClockTick, masterClockTick, memClockTick, hsHostClockTick;
    logic fsHost48mClockTick, fsHost12mClockTick, progClockOutA, progClockOutB;
    logic [31:0] periphClockTick;
    logic [1:0] modeState;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int c[10];
    // source periods in core cycles: usb pll, main pll, slow, oscillator
    int per[4] = '{3, 2, 7, 5};
    int ph[4] = '{0, 0, 0, 0};
    int divs[4] = '{1, 2, 4, 3};

    always #50 core_clk = ~core_clk;

    power_clock_manager #(.NUM_PERIPH(32)) power_clock_manager_inst (
        .core_clk(core_clk), .rst_b(rst_b),
        .usbPllTick(usbPllTick), .mainPllTick(mainPllTick),
        .slowTick(slowTick), .mainOscTick(mainOscTick),
        .sysSrcSel(sysSrcSel), .sysPresSel(sysPresSel),
        .masterDivSelect(masterDivSelect), .fsUsbSrcSel(fsUsbSrcSel),
        .fsUsbDivider(fsUsbDivider), .periphClkEn(periphClkEn),
        .progASrcSel(progASrcSel), .progAPresSel(progAPresSel),
        .progBSrcSel(progBSrcSel), .progBPresSel(progBPresSel),
        .modeReq(modeReq), .modeReqCode(modeReqCode), .wakeIrq(wakeIrq),
        .procClockTick(procClockTick), .masterClockTick(masterClockTick),
        .memClockTick(memClockTick), .hsHostClockTick(hsHostClockTick),
        .fsHost48mClockTick(fsHost48mClockTick),
        .fsHost12mClockTick(fsHost12mClockTick),
        .periphClockTick(periphClockTick), .progClockOutA(progClockOutA),
        .progClockOutB(progClockOutB), .modeState(modeState)
    );

    always @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            ph[i] <= (ph[i] == per[i] - 1) ? 0 : ph[i] + 1;
        end
        // usb pll ticks through every test, so high-speed host use stays legal
        usbPllTick <= (ph[0] == per[0] - 1);
        mainPllTick <= (ph[1] == per[1] - 1);
        slowTick <= (ph[2] == per[2] - 1);
        mainOscTick <= (ph[3] == per[3] - 1);
    end

    task automatic print_verdict();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // a hung run still ends in the one closing report
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : settle

    // counts sampled mid-cycle, where the registered ticks are settled
    task automatic measure(input int w);
        logic [9:0] v;
        c = '{default: 0};
        repeat (w) begin
            @(negedge core_clk);
            v = {progClockOutB, progClockOutA, periphClockTick[1:0], fsHost12mClockTick,
                 fsHost48mClockTick, hsHostClockTick, memClockTick, masterClockTick,
                 procClockTick};
            for (int i = 0; i < 10; i++) begin
                if (v[i] === 1'b1) c[i]++;
            end
        end
    endtask : measure

    task automatic request(input logic [1:0] code);
        @(posedge core_clk);
        modeReq <= 1'b1;
        modeReqCode <= code;
        @(posedge core_clk);
        modeReq <= 1'b0;
        settle(200);
    endtask : request

    task automatic wake();
        @(posedge core_clk);
        wakeIrq <= 1'b1;
        @(posedge core_clk);
        wakeIrq <= 1'b0;
        settle(200);
    endtask : wake

    initial begin
        settle(19);
        @(posedge core_clk);
        rst_b <= 1'b1;
        settle(300);
        measure(840);
        check("proc", c[0], 120);
        check("master", c[1], 120);
        check("mem", c[2], 0);
        check("hs", c[3], 280);
        check("fs48", c[4], 28);
        check("fs12", c[5], 7);
        check("periph0", c[6], 120);
        check("periph1", c[7], 0);
        check("progA", c[8], 120);
        check("progB", c[9], 120);
        $display("test defaults done");
        @(posedge core_clk);
        sysSrcSel <= power_clock_pkg::SRC_USB_PLL;
        sysPresSel <= 3'h1;
        masterDivSelect <= power_clock_pkg::MASTER_DIV_SELECT_DIV3;
        fsUsbSrcSel <= 1'b1;
        fsUsbDivider <= 4'h7;
        periphClkEn <= 32'h00000002;
        progASrcSel <= power_clock_pkg::SRC_MAIN_OSC;
        progAPresSel <= 3'h6;
        progBSrcSel <= power_clock_pkg::SRC_MAIN_PLL;
        progBPresSel <= 3'h2;
        settle(900);
        measure(2880);
        check("proc", c[0], 480);
        check("master", c[1], 160);
        check("mem", c[2], 320);
        check("fs48", c[4], 180);
        check("fs12", c[5], 45);
        check("periph0", c[6], 0);
        check("periph1", c[7], 160);
        check("progA", c[8], 9);
        check("progB", c[9], 360);
        $display("test switched sources done");
        @(posedge core_clk);
        sysSrcSel <= power_clock_pkg::SRC_MAIN_PLL;
        sysPresSel <= 3'h0;
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            masterDivSelect <= 2'(m);
            settle(300);
            measure(840);
            check("master", c[1], 420 / divs[m]);
            check("mem", c[2], (divs[m] == 1) ? 0 : 840 / divs[m]);
        end
        $display("test master divider done");
        @(posedge core_clk);
        masterDivSelect <= power_clock_pkg::MASTER_DIV_SELECT_DIV1;
        settle(100);
        request(power_clock_pkg::MODE_IDLE);
        check("mode", {30'h0, modeState}, 32'h1);
        measure(840);
        check("proc", c[0], 0);
        check("master", c[1], 420);
        wake();
        check("mode", {30'h0, modeState}, 32'h0);
        measure(840);
        check("proc", c[0], 420);
        $display("test idle done");
        request(power_clock_pkg::MODE_SLOW);
        measure(840);
        check("proc", c[0], 120);
        check("periph1", c[7], 120);
        request(power_clock_pkg::MODE_STANDBY);
        check("mode", {30'h0, modeState}, 32'h3);
        measure(840);
        check("proc", c[0], 0);
        check("master", c[1], 120);
        wake();
        check("mode", {30'h0, modeState}, 32'h2);
        $display("test low power modes done");
        // mid-run reset: proc, hs and progA ticks silent, mode back to normal, sources relatch
        @(posedge core_clk);
        rst_b <= 1'b0;
        settle(5);
        measure(100);
        check("mode", {30'h0, modeState}, 32'h0);
        check("proc", c[0], 0);
        check("hs", c[3], 0);
        check("progA", c[8], 0);
        @(posedge core_clk);
        rst_b <= 1'b1;
        settle(300);
        measure(840);
        check("proc", c[0], 420);
        check("master", c[1], 420);
        check("mem", c[2], 0);
        $display("test reset done");
        print_verdict();
    end
endmodule : tb
